// [inc/gppc_defines.svh]
`ifndef GPPC_DEFINES_SVH
`define GPPC_DEFINES_SVH
// Port select and word index within a port window
`define GPPC_PORT_LSB 13
`define GPPC_IDX_DIR 4'h0
`define GPPC_IDX_INEN 4'h1
`define GPPC_IDX_PU 4'h2
`define GPPC_IDX_PD 4'h3
`define GPPC_IDX_OD 4'h4
`define GPPC_IDX_DRV 4'h5
`define GPPC_IDX_LOCK 4'h6
`define GPPC_IDX_DIN 4'h7
`define GPPC_IDX_DOUT 4'h8
`define GPPC_IDX_SETRST 4'h9
`define GPPC_IDX_RST 4'hA
`define GPPC_LOCK_KEY 16'h5FA0
`define GPPC_PA_INEN_RST 16'h0200
`define GPPC_PA_PU_RST 16'h3200
`define GPPC_PA_MASK 16'hFFFF
`define GPPC_PB_MASK 16'hFFFF
`define GPPC_PC_MASK 16'h00FF
`endif

// [inc/gppc_pkg.sv]
package gppc_pkg;
  typedef logic [2:0][15:0] gppc_port16_t;
  typedef struct packed {
    gppc_port16_t dir;
    gppc_port16_t inen;
    gppc_port16_t pu;
    gppc_port16_t pd;
    gppc_port16_t od;
    gppc_port16_t dout;
    gppc_port16_t lock;
    gppc_port16_t sync1;
    gppc_port16_t sync2;
    logic [2:0][31:0] drv;
    logic [2:0] lock_en;
    logic [31:0] prdata;
    logic pslverr;
  } gppc_state_t;
  typedef struct packed {
    logic [39:0] analog_n;
    logic [39:0] altfunc_output_enable_n;
    logic [39:0] altfunc_input_enable_n;
  } gppc_af_ctl_t;
  typedef struct packed {
    logic [39:0] pad_analog_enable_n;
    logic [39:0] pad_output_enable_n;
    logic [39:0] pad_input_enable_n;
    logic [39:0] pad_dout;
    logic [39:0] pull_up_en;
    logic [39:0] pull_down_en;
    logic [39:0] open_drain;
    logic [79:0] drive;
    logic [39:0] pin_locked;
  } gppc_pad_ctl_t;
endpackage : gppc_pkg

// [hdl/gppc_top.sv]
// What this block does
// - Forty pins: port A 16, port B 16, port C 8, own registers each.
// - Reset leaves alternate functions off, pins input-disabled, no pulls.
// - Boot and debug pins leave reset with pull-up enabled; only port A pin 9 also has input enabled.
// - One direction bit per pin in the direction control register.
// - Direction 0 means input, 1 means output.
// - Pad level reads in input data only while input enable set.
// - Input enable clear turns buffer off; input reads zero.
// - Pull-up wins over pull-down when both selected.
// - Output pins are driven from the output data register bit.
// - Open-drain bit clear gives push-pull, set gives open-drain.
// - Open-drain pins ignore pull-up and pull-down selections.
// - Set/reset writes touch only bits written as one.
// - Set wins over reset for the same bit in one write.
// - Two-bit drive current field per pin in drive select register.
// - In GPIO mode pad enables follow direction and input enable.
// - Analog, output and input pad enables follow the mode table.
// - An engaged port lock holds until reset.
// - Write 0x5FA0_0001 reads back enabled and freezes pin 0 only.
//
// The register offsets and register access over APB were left to the implementer.
`timescale 1ns/10ps
`include "gppc_defines.svh"
module gppc_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [14:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [39:0] pad_in,
  input wire gppc_pkg::gppc_af_ctl_t af_ctl,
  output gppc_pkg::gppc_pad_ctl_t pad_ctl
);
  gppc_pkg::gppc_state_t st_ff;
  gppc_pkg::gppc_state_t nxt_st;
  logic [47:0] pad_in48;
  logic [1:0] port_sel;
  logic [3:0] idx;
  logic wr_en;
  logic rd_setup;

  // Pins implemented in each port; unimplemented bits stay zero
  function automatic logic [15:0] port_mask(input int p);
    if (p == 0) begin
      port_mask = `GPPC_PA_MASK;
    end else if (p == 1) begin
      port_mask = `GPPC_PB_MASK;
    end else begin
      port_mask = `GPPC_PC_MASK;
    end
  endfunction : port_mask

  // Keep locked bits, take written bits elsewhere
  function automatic logic [15:0] merge16(input logic [15:0] old_v,
      input logic [15:0] new_v, input logic [15:0] lk, input logic [15:0] pm);
    merge16 = (old_v & lk) | (new_v & ~lk & pm);
  endfunction : merge16

  function automatic logic [31:0] widen2(input logic [15:0] m);
    logic [31:0] r;
    r = 32'h0000_0000;
    for (int i = 0; i < 16; i++) begin
      r[2*i +: 2] = {2{m[i]}};
    end
    widen2 = r;
  endfunction : widen2

  function automatic logic idx_mapped(input logic [1:0] ps,
      input logic [3:0] ix);
    idx_mapped = (ps != 2'h3) && (ix <= `GPPC_IDX_RST);
  endfunction : idx_mapped

  assign pad_in48 = {8'h00, pad_in};
  assign port_sel = paddr[`GPPC_PORT_LSB +: 2];
  assign idx = paddr[5:2];
  assign wr_en = psel & penable & pwrite;
  assign rd_setup = psel & ~penable;

  always_comb begin
    logic [15:0] pm;
    logic [15:0] lk;
    logic [31:0] rd;
    logic [15:0] setb;
    logic [15:0] rstb;
    pm = 16'h0000;
    lk = 16'h0000;
    rd = 32'h0000_0000;
    setb = 16'h0000;
    rstb = 16'h0000;
    nxt_st = st_ff;
    for (int p = 0; p < 3; p++) begin
      // First stage feeds only the second
      nxt_st.sync1[p] = pad_in48[16*p +: 16] & port_mask(p);
      nxt_st.sync2[p] = st_ff.sync1[p];
      pm = port_mask(p);
      lk = st_ff.lock[p];
      if (wr_en && port_sel == p[1:0]) begin
        if (idx == `GPPC_IDX_DIR) begin
          nxt_st.dir[p] = merge16(st_ff.dir[p], pwdata[15:0], lk,
            pm);
        end else if (idx == `GPPC_IDX_INEN) begin
          nxt_st.inen[p] = merge16(st_ff.inen[p], pwdata[15:0], lk, pm);
        end else if (idx == `GPPC_IDX_PU) begin
          nxt_st.pu[p] = merge16(st_ff.pu[p], pwdata[15:0], lk, pm);
        end else if (idx == `GPPC_IDX_PD) begin
          nxt_st.pd[p] = merge16(st_ff.pd[p], pwdata[15:0], lk, pm);
        end else if (idx == `GPPC_IDX_OD) begin
          nxt_st.od[p] = merge16(st_ff.od[p], pwdata[15:0], lk,
            pm);
        end else if (idx == `GPPC_IDX_DRV) begin
          nxt_st.drv[p] = (st_ff.drv[p] & widen2(lk)) |
            (pwdata & widen2(~lk & pm));
        end else if (idx == `GPPC_IDX_LOCK) begin
          // Once engaged nothing but reset reopens the port
          if (!st_ff.lock_en[p] &&
              pwdata[31:16] == `GPPC_LOCK_KEY) begin
            nxt_st.lock_en[p] = 1'b1;
            nxt_st.lock[p] = pwdata[15:0] & pm;
          end
        end else if (idx == `GPPC_IDX_DOUT) begin
          nxt_st.dout[p] = pwdata[15:0] & pm;
        end else if (idx == `GPPC_IDX_SETRST) begin
          setb = pwdata[15:0] & pm;
          rstb = pwdata[31:16] & pm;
          // Set applied last so it overrides a reset of the same bit
          nxt_st.dout[p] = (st_ff.dout[p] & ~rstb) | setb;
        end else if (idx == `GPPC_IDX_RST) begin
          rstb = pwdata[15:0] & pm;
          nxt_st.dout[p] = st_ff.dout[p] & ~rstb;
        end
      end
      if (port_sel == p[1:0]) begin
        if (idx == `GPPC_IDX_DIR) begin
          rd = {16'h0000, st_ff.dir[p]};
        end else if (idx == `GPPC_IDX_INEN) begin
          rd = {16'h0000, st_ff.inen[p]};
        end else if (idx == `GPPC_IDX_PU) begin
          rd = {16'h0000, st_ff.pu[p]};
        end else if (idx == `GPPC_IDX_PD) begin
          rd = {16'h0000, st_ff.pd[p]};
        end else if (idx == `GPPC_IDX_OD) begin
          rd = {16'h0000, st_ff.od[p]};
        end else if (idx == `GPPC_IDX_DRV) begin
          rd = st_ff.drv[p];
        end else if (idx == `GPPC_IDX_LOCK) begin
          rd = {st_ff.lock_en[p] ? `GPPC_LOCK_KEY : 16'h0000,
            st_ff.lock[p]};
        end else if (idx == `GPPC_IDX_DIN) begin
          rd = {16'h0000, st_ff.sync2[p] & st_ff.inen[p]};
        end else if (idx == `GPPC_IDX_DOUT) begin
          rd = {16'h0000, st_ff.dout[p]};
        end else begin
          rd = 32'h0000_0000;
        end
      end
    end
    // Read data is captured in the setup cycle so the access can end at once
    if (rd_setup) begin
      nxt_st.prdata = pwrite ? 32'h0000_0000 : rd;
      nxt_st.pslverr = ~idx_mapped(port_sel, idx);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
      st_ff.inen[0] <= `GPPC_PA_INEN_RST;
      st_ff.pu[0] <= `GPPC_PA_PU_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pready = 1'b1;
  assign prdata = st_ff.prdata;
  assign pslverr = st_ff.pslverr & psel & penable;

  genvar g;
  generate
    for (g = 0; g < 40; g++) begin : g_pin
      localparam int P = g / 16;
      localparam int N = g % 16;
      logic dir_b;
      logic inen_b;
      logic od_b;
      logic pu_b;
      logic pd_b;
      logic ana_n;
      logic afo_n;
      logic afi_n;
      assign dir_b = st_ff.dir[P][N];
      assign inen_b = st_ff.inen[P][N];
      assign od_b = st_ff.od[P][N];
      assign pu_b = st_ff.pu[P][N];
      assign pd_b = st_ff.pd[P][N];
      assign ana_n = af_ctl.analog_n[g];
      assign afo_n = af_ctl.altfunc_output_enable_n[g];
      assign afi_n = af_ctl.altfunc_input_enable_n[g];
      // Analog modes take precedence; pad stays output-disabled there
      always_comb begin
        if (!ana_n) begin
          pad_ctl.pad_analog_enable_n[g] = 1'b0;
          pad_ctl.pad_output_enable_n[g] = 1'b1;
          pad_ctl.pad_input_enable_n[g] = ~inen_b;
        end else if (!afo_n) begin
          pad_ctl.pad_analog_enable_n[g] = 1'b1;
          pad_ctl.pad_output_enable_n[g] = 1'b0;
          pad_ctl.pad_input_enable_n[g] = ~inen_b;
        end else if (!afi_n) begin
          pad_ctl.pad_analog_enable_n[g] = 1'b1;
          pad_ctl.pad_output_enable_n[g] = 1'b1;
          pad_ctl.pad_input_enable_n[g] = 1'b0;
        end else begin
          pad_ctl.pad_analog_enable_n[g] = 1'b1;
          pad_ctl.pad_output_enable_n[g] = ~dir_b;
          pad_ctl.pad_input_enable_n[g] = ~inen_b;
        end
      end
      assign pad_ctl.pad_dout[g] = st_ff.dout[P][N];
      assign pad_ctl.open_drain[g] = od_b;
      assign pad_ctl.pull_up_en[g] = pu_b & ~od_b;
      assign pad_ctl.pull_down_en[g] = pd_b & ~pu_b &
        ~od_b;
      assign pad_ctl.drive[2*g +: 2] = st_ff.drv[P][2*N +: 2];
      assign pad_ctl.pin_locked[g] = st_ff.lock[P][N];
    end
  endgenerate
endmodule : gppc_top

// [dv/gppc_pad_model.sv]
`timescale 1ns/10ps
module gppc_pad_model (
  input wire logic pclk,
  input wire gppc_pkg::gppc_pad_ctl_t pad_ctl,
  input wire logic [39:0] ext_en,
  input wire logic [39:0] ext_val,
  output logic [39:0] pad_in
);
  logic [39:0] flt_ff = '0;
  logic [39:0] hi;
  logic [39:0] lo;
  // Undriven pads wander, so a float never reads as a steady level
  always @(posedge pclk) flt_ff <= ~flt_ff;
  assign lo = ~pad_ctl.pad_output_enable_n & ~pad_ctl.pad_dout;
  assign hi = ~pad_ctl.pad_output_enable_n & ~pad_ctl.open_drain &
    pad_ctl.pad_dout;
  assign pad_in = ~lo & (hi | (ext_en & ext_val) | (~ext_en &
    (pad_ctl.pull_up_en | (~pad_ctl.pull_down_en & flt_ff))));
endmodule : gppc_pad_model

// [dv/gppc_props.sv]
`timescale 1ns/10ps
module gppc_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [14:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [39:0] pad_in,
  input wire gppc_pkg::gppc_af_ctl_t af_ctl,
  input wire gppc_pkg::gppc_pad_ctl_t pad_ctl
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire [5:0] pi = {paddr[14:13], paddr[5:2]};
  wire [15:0] db = pad_ctl.pad_dout[31:16];
  pull_prio_a: assert property (
    (pad_ctl.pull_up_en & pad_ctl.pull_down_en) == '0) else $error("pulls");
  od_nopull_a: assert property (
    ((pad_ctl.pull_up_en | pad_ctl.pull_down_en) & pad_ctl.open_drain) == '0)
    else $error("od pull");
  analog_en_a: assert property (
    pad_ctl.pad_analog_enable_n == af_ctl.analog_n) else $error("analog");
  af_out_a: assert property ((af_ctl.analog_n &
    ~af_ctl.altfunc_output_enable_n & pad_ctl.pad_output_enable_n) == '0)
    else $error("af out");
  af_in_a: assert property ((af_ctl.analog_n &
    af_ctl.altfunc_output_enable_n & ~af_ctl.altfunc_input_enable_n &
    (~pad_ctl.pad_output_enable_n | pad_ctl.pad_input_enable_n)) == '0)
    else $error("af in");
  dout_write_a: assert property (wr && pi == 6'h08 |=>
    pad_ctl.pad_dout[15:0] == $past(pwdata[15:0])) else $error("dout");
  set_wins_a: assert property (wr && pi == 6'h19 |=>
    db == (($past(db) & ~$past(pwdata[31:16])) | $past(pwdata[15:0])))
    else $error("set reset");
  rst_only_a: assert property (wr && pi == 6'h2A |=>
    pad_ctl.pad_dout[39:32] == ($past(pad_ctl.pad_dout[39:32]) &
    ~$past(pwdata[7:0]))) else $error("reset only");
  wo_read_a: assert property (acc && !pwrite &&
    paddr[14:13] != 2'h3 && paddr[5:2] inside {4'h9, 4'hA} |->
    prdata == '0) else $error("read zero");
  unmap_err_a: assert property (
    acc && paddr[14:13] == 2'h3 |-> pslverr) else $error("unmapped");
  cover property (wr && pi == 6'h19);
  cover property (wr && paddr[5:2] == 4'h6);
  cover property (acc && pslverr);
endmodule : gppc_props
bind gppc_top gppc_props u_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .pad_in(pad_in), .af_ctl(af_ctl), .pad_ctl(pad_ctl));

// [dv/gpio_port_pad_control_test.sv]
`timescale 1ns/10ps
module gpio_port_pad_control_test;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [14:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [39:0] pad_in;
  logic [39:0] ext_en = '0;
  logic [39:0] ext_val = '0;
  gppc_pkg::gppc_af_ctl_t af_ctl = '1;
  gppc_pkg::gppc_pad_ctl_t pad_ctl;
  int err_count = 0;
  int compares = 0;
  logic [31:0] rd;
  logic er;
  localparam logic [31:0] TAB [9][4] = '{
    '{32'h0, 32'hA5A5, 32'hA5A5, 32'h0}, '{32'h2004, 32'hF0, 32'hF0, 32'h0},
    '{32'h4008, 32'hFF0F, 32'hF, 32'h0},
    '{32'h2014, 32'hDEADBEEF, 32'hDEADBEEF, 32'h0},
    '{32'h20, 32'h1234, 32'h1234, 32'h0}, '{32'h2024, 32'h70005, 32'h0, 32'h0},
    '{32'h4028, 32'h1, 32'h0, 32'h0}, '{32'h2C, 32'h1, 32'h0, 32'h1},
    '{32'h6000, 32'h1, 32'h0, 32'h1}};
  gppc_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pad_in(pad_in),
    .af_ctl(af_ctl), .pad_ctl(pad_ctl));
  gppc_pad_model u_pad (.pclk(pclk), .pad_ctl(pad_ctl), .ext_en(ext_en),
    .ext_val(ext_val), .pad_in(pad_in));
  initial begin
    forever #2.5 pclk = ~pclk;
  end
  task automatic check(input string nm, input logic [79:0] got,
    input logic [79:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  task automatic close_out;
    $display("mismatches %0d comparisons %0d", err_count, compares);
    if (err_count == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : close_out
  task automatic apb(input logic w, input logic [14:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_count++;
      close_out();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      apb(1'b1, TAB[i][0][14:0], TAB[i][1]);
      apb(1'b0, TAB[i][0][14:0], 32'h0);
      check("row data", rd, TAB[i][2]);
      check("row error", er, TAB[i][3]);
    end
    @(negedge pclk);
    check("set wins", pad_ctl.pad_dout[31:16], 16'h0005);
    check("drive", pad_ctl.drive[63:32], 32'hDEADBEEF);
    @(posedge pclk);
    presetn <= 1'b0;
    @(negedge pclk);
    check("rst ien", pad_ctl.pad_input_enable_n, 40'hFFFFFFFDFF);
    check("rst pu", pad_ctl.pull_up_en, 40'h0000003200);
    check("rst oe", pad_ctl.pad_output_enable_n, 40'hFFFFFFFFFF);
    @(posedge pclk);
    presetn <= 1'b1;
    ext_en <= 40'h0000000202;
    ext_val <= 40'h0000000202;
    apb(1'b0, 15'h0004, 32'h0);
    check("inen rst", rd, 32'h00000200);
    apb(1'b0, 15'h001C, 32'h0);
    check("din gated", rd, 32'h00000200);
    apb(1'b1, 15'h0000, 32'h000F);
    apb(1'b1, 15'h0004, 32'h020F);
    apb(1'b1, 15'h0024, 32'h00070005);
    apb(1'b1, 15'h0028, 32'h00000001);
    // The new pad level needs both synchroniser stages before it reads back
    repeat (2) @(posedge pclk);
    apb(1'b0, 15'h001C, 32'h0);
    check("loopback", rd, 32'h00000204);
    check("gpio oe", pad_ctl.pad_output_enable_n[3:0], 4'h0);
    check("gpio ie", pad_ctl.pad_input_enable_n[3:0], 4'h0);
    apb(1'b1, 15'h0008, 32'h3204);
    apb(1'b1, 15'h0010, 32'h0004);
    apb(1'b1, 15'h2008, 32'h0001);
    apb(1'b1, 15'h200C, 32'h0003);
    af_ctl.analog_n[20] <= 1'b0;
    af_ctl.altfunc_output_enable_n[21] <= 1'b0;
    af_ctl.altfunc_input_enable_n[22] <= 1'b0;
    @(negedge pclk);
    check("od", {pad_ctl.open_drain[2], pad_ctl.pull_up_en[2]},
      2'h2);
    check("pull", {pad_ctl.pull_up_en[17:16], pad_ctl.pull_down_en[17:16]},
      4'h6);
    check("af an", pad_ctl.pad_analog_enable_n[22:20], 3'h6);
    check("af oe", pad_ctl.pad_output_enable_n[22:21], 2'h2);
    check("af ie", pad_ctl.pad_input_enable_n[22], 1'b0);
    apb(1'b1, 15'h0018, 32'h5FA00001);
    apb(1'b1, 15'h0000, 32'hFFF0);
    apb(1'b0, 15'h0000, 32'h0);
    check("frozen", rd, 32'h0000FFF1);
    apb(1'b1, 15'h0018, 32'h0);
    apb(1'b0, 15'h0018, 32'h0);
    check("lock held", rd, 32'h5FA00001);
    check("locked", pad_ctl.pin_locked[1:0], 2'h1);
    close_out();
  end
endmodule : gpio_port_pad_control_test
